// ==== verification/conditional_branch_unit_tb.sv ====
`default_nettype none
`define CHK(a, b, m) begin total_checks++; if ((a) !== (b)) begin fails++; $display("[FAIL] %0t %s", $time, m); end end
module conditional_branch_unit_tb
   import branch_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0;
   logic rst_b = 1'b0;
   logic issue = 1'b0;
   logic [3:0] op = 4'h0;
   logic [FLAG_IDX_W-1:0] flag_idx = 3'h0;
   logic [OFS_W-1:0] offset = 7'h00;
   logic [PC_W-1:0] pc_in = 16'h0000;
   logic [7:0] status_flags_word = 8'h00;
   logic busy, done, taken_r, pc_load_r, flags_write;
   logic [PC_W-1:0] pc_target_r;
   int fails = 0;
   int total_checks = 0;
   int cycles = 0;
   conditional_branch_unit u_conditional_branch_unit (.ref_clk(ref_clk), .rst_b(rst_b), .issue(issue), .op(op),
      .flag_idx(flag_idx), .offset(offset), .pc_in(pc_in), .status_flags_word(status_flags_word), .busy(busy),
      .done(done), .taken_r(taken_r), .pc_load_r(pc_load_r), .pc_target_r(pc_target_r), .flags_write(flags_write));
   always #5 ref_clk = ~ref_clk;
   task give_verdict;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 1000) begin
         fails++;
         give_verdict();
      end
   end
   // One branch; while busy the flags flip with issue held, which must be ignored
   task br(input logic [3:0] o, input logic [2:0] i, input logic [6:0] k, input logic [15:0] pc,
      input logic [7:0] f, input logic t);
      @(posedge ref_clk);
      issue <= 1'b1;
      op <= o;
      flag_idx <= i;
      offset <= k;
      pc_in <= pc;
      status_flags_word <= f;
      @(negedge ref_clk);
      `CHK(done, !t, "done in accept cycle")
      `CHK({busy, pc_load_r, taken_r, flags_write}, 4'h0, "quiet outputs")
      if (t) begin
         @(posedge ref_clk);
         status_flags_word <= ~f;
         @(negedge ref_clk);
         `CHK({busy, done, pc_load_r, taken_r, flags_write}, 5'h1E, "taken pulse")
         `CHK(pc_target_r, pc + {{9{k[6]}}, k} + 16'h0001, "target")
      end
   endtask
   task pair(input logic [3:0] o, input logic [2:0] b, input logic t);
      br(o, 3'h0, 7'h7E, 16'h0200, 8'h01 << b, t);
      br(o, 3'h0, 7'h7E, 16'h0200, ~(8'h01 << b), !t);
   endtask
   task t_flag_bits;
      for (int b = 0; b < 8; b++) begin
         br(OP_FLAG_SET, 3'(b), 7'h05, 16'h0100, 8'h01 << b, 1'b1);
         br(OP_FLAG_SET, 3'(b), 7'h05, 16'h0100, ~(8'h01 << b), 1'b0);
         br(OP_FLAG_CLEAR, 3'(b), 7'h3F, 16'h0100, ~(8'h01 << b), 1'b1);
         br(OP_FLAG_CLEAR, 3'(b), 7'h3F, 16'h0100, 8'h01 << b, 1'b0);
      end
      $display("test flag bits done");
   endtask
   task t_fixed;
      pair(OP_EQUAL, FLAG_Z, 1'b1);
      pair(OP_NOT_EQUAL, FLAG_Z, 1'b0);
      pair(OP_CARRY_SET, FLAG_C, 1'b1);
      pair(OP_UNSIGNED_LOWER, FLAG_C, 1'b1);
      pair(OP_CARRY_CLEAR, FLAG_C, 1'b0);
      pair(OP_SAME_OR_HIGHER, FLAG_C, 1'b0);
      pair(OP_NEGATIVE, FLAG_N, 1'b1);
      pair(OP_POSITIVE, FLAG_N, 1'b0);
      pair(OP_HALF_SET, FLAG_H, 1'b1);
      pair(OP_HALF_CLEAR, FLAG_H, 1'b0);
      pair(OP_COPY_BIT_SET, FLAG_T, 1'b1);
      $display("test single flag ops done");
   endtask
   task t_signed;
      logic [7:0] f;
      for (int j = 0; j < 4; j++) begin
         f = 8'(j << 2);
         br(OP_SIGNED_GE, 3'h0, 7'h10, 16'h4000, f, ~(f[2] ^ f[3]));
         br(OP_SIGNED_LESS, 3'h0, 7'h10, 16'h4000, f, f[2] ^ f[3]);
      end
      $display("test signed done");
   endtask
   task t_timing;
      br(OP_EQUAL, 3'h0, 7'h40, 16'h0010, 8'h02, 1'b1);
      br(OP_EQUAL, 3'h0, 7'h01, 16'hFFFF, 8'h02, 1'b1);
      br(OP_NEGATIVE, 3'h0, 7'h3F, 16'h1234, 8'h04, 1'b1);
      br(OP_NONE, 3'h0, 7'h05, 16'h0100, 8'hFF, 1'b0);
      @(posedge ref_clk);
      issue <= 1'b0;
      @(negedge ref_clk);
      `CHK({done, busy, pc_load_r, pc_target_r}, {3'h0, 16'h1274}, "idle holds target")
      $display("test timing done");
   endtask
   initial begin
      repeat (11) @(posedge ref_clk);
      @(negedge ref_clk);
      `CHK({busy, pc_load_r, taken_r, pc_target_r}, 19'h0, "reset values")
      @(posedge ref_clk);
      rst_b <= 1'b1;
      t_flag_bits();
      t_fixed();
      t_signed();
      t_timing();
      give_verdict();
   end
endmodule
`undef CHK
`default_nettype wire

// ==== verilog/branch_condition.sv ====
`default_nettype none
module branch_condition
   import branch_pkg::*;
(
   input wire logic [3:0] op,
   input wire logic [FLAG_IDX_W-1:0] flag_idx,
   input wire logic [7:0] status_flags_word,
   output logic cond_true
);
   logic c_f, z_f, n_f, v_f, h_f, t_f;
   assign c_f = status_flags_word[FLAG_C];
   assign z_f = status_flags_word[FLAG_Z];
   assign n_f = status_flags_word[FLAG_N];
   assign v_f = status_flags_word[FLAG_V];
   assign h_f = status_flags_word[FLAG_H];
   assign t_f = status_flags_word[FLAG_T];

   always_comb begin
      unique case (op)
         OP_FLAG_SET: cond_true = status_flags_word[flag_idx]; // RULE1
         OP_FLAG_CLEAR: cond_true = ~status_flags_word[flag_idx]; // RULE2
         OP_EQUAL: cond_true = z_f; // RULE3
         OP_NOT_EQUAL: cond_true = ~z_f; // RULE4
         OP_CARRY_SET, OP_UNSIGNED_LOWER: cond_true = c_f; // RULE5
         OP_CARRY_CLEAR, OP_SAME_OR_HIGHER: cond_true = ~c_f; // RULE6
         OP_NEGATIVE: cond_true = n_f; // RULE7
         OP_POSITIVE: cond_true = ~n_f; // RULE8
         OP_SIGNED_GE: cond_true = ~(n_f ^ v_f); // RULE9
         OP_SIGNED_LESS: cond_true = n_f ^ v_f; // RULE10
         OP_HALF_SET: cond_true = h_f; // RULE11
         OP_HALF_CLEAR: cond_true = ~h_f; // RULE12
         OP_COPY_BIT_SET: cond_true = t_f; // RULE13
         OP_NONE: cond_true = 1'b0;
      endcase
   end
endmodule
`default_nettype wire

// ==== verilog/branch_pkg.sv ====
`default_nettype none
package branch_pkg;
   localparam int PC_W = 16;
   localparam int OFS_W = 7;
   localparam int FLAG_IDX_W = 3;
   // Status flag bit positions
   localparam logic [2:0] FLAG_C = 3'h0;
   localparam logic [2:0] FLAG_Z = 3'h1;
   localparam logic [2:0] FLAG_N = 3'h2;
   localparam logic [2:0] FLAG_V = 3'h3;
   localparam logic [2:0] FLAG_S = 3'h4;
   localparam logic [2:0] FLAG_H = 3'h5;
   localparam logic [2:0] FLAG_T = 3'h6;
   localparam logic [2:0] FLAG_I = 3'h7;
   localparam logic [15:0] PC_RESET = 16'h0000;
   localparam logic [15:0] PC_STEP = 16'h0001;
   localparam int TAKEN_CYCLES = 2;
   localparam int NOT_TAKEN_CYCLES = 1;
   typedef enum logic [3:0] {
      OP_NONE = 4'h0,
      OP_FLAG_SET = 4'h1,
      OP_FLAG_CLEAR = 4'h2,
      OP_EQUAL = 4'h3,
      OP_NOT_EQUAL = 4'h4,
      OP_CARRY_SET = 4'h5,
      OP_UNSIGNED_LOWER = 4'h6,
      OP_CARRY_CLEAR = 4'h7,
      OP_SAME_OR_HIGHER = 4'h8,
      OP_NEGATIVE = 4'h9,
      OP_POSITIVE = 4'hA,
      OP_SIGNED_GE = 4'hB,
      OP_SIGNED_LESS = 4'hC,
      OP_HALF_SET = 4'hD,
      OP_HALF_CLEAR = 4'hE,
      OP_COPY_BIT_SET = 4'hF
   } branch_op_e;
   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_JUMP = 1'b1
   } branch_state_e;
endpackage
`default_nettype wire

// ==== verilog/conditional_branch_unit.sv ====
`default_nettype none
// Behaviour
// [RULE1] Flag-set branch: selected flag one jumps
// [RULE2] Flag-clear branch: selected flag zero jumps
// [RULE3] Equal branch jumps when zero flag set
// [RULE4] Not-equal branch jumps when zero clear
// [RULE5] Carry-set and lower identical, carry one
// [RULE6] Carry-clear and same-or-higher identical, carry zero
// [RULE7] Negative branch jumps when negative flag set
// [RULE8] Positive branch jumps when negative clear
// [RULE9] Signed-ge jumps when N xor V zero
// [RULE10] Signed-less jumps when N xor V one
// [RULE11] Half-set jumps when half-carry one
// [RULE12] Half-clear jumps when half-carry zero
// [RULE13] Copy-bit-set jumps when T flag one
// [RULE14] False one cycle, taken two, signed offset
module conditional_branch_unit
   import branch_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic issue,
   input wire logic [3:0] op,
   input wire logic [FLAG_IDX_W-1:0] flag_idx,
   input wire logic [OFS_W-1:0] offset,
   input wire logic [PC_W-1:0] pc_in,
   input wire logic [7:0] status_flags_word,
   output logic busy,
   output logic done,
   output logic taken_r,
   output logic pc_load_r,
   output logic [PC_W-1:0] pc_target_r,
   output logic flags_write
);
   branch_state_e state_r;
   logic cond_true;
   logic accept;
   logic [PC_W-1:0] target_nxt;

   branch_condition u_cond (
      .op(op),
      .flag_idx(flag_idx),
      .status_flags_word(status_flags_word),
      .cond_true(cond_true)
   );

   assign busy = (state_r == ST_JUMP);
   assign accept = issue && !busy;
   // Word displacement, sign extended
   assign target_nxt = pc_in + {{(PC_W-OFS_W){offset[OFS_W-1]}}, offset} + PC_STEP; // RULE14
   // Branches never modify status flags
   assign flags_write = 1'b0; // RULE1
   // Instruction retires at the end of cycle one (not taken) or two (taken)
   assign done = (accept && !cond_true) || busy; // RULE14

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         state_r <= ST_IDLE;
      end else if (accept && cond_true) begin
         state_r <= ST_JUMP; // RULE14
      end else begin
         state_r <= ST_IDLE;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         taken_r <= 1'b0;
         pc_load_r <= 1'b0;
         pc_target_r <= PC_RESET;
      end else begin
         taken_r <= accept && cond_true;
         pc_load_r <= accept && cond_true;
         if (accept && cond_true) begin
            pc_target_r <= target_nxt;
         end
      end
   end

   sequence s_take;
      accept && cond_true;
   endsequence
   sequence s_load;
      pc_load_r && busy && (pc_target_r == $past(target_nxt));
   endsequence

   property p_taken_load;
      @(posedge ref_clk) disable iff (!rst_b)
         s_take |=> s_load;
   endproperty
   a_taken_load: assert property (p_taken_load) else $error("taken branch did not load target"); // RULE14

   property p_not_taken;
      @(posedge ref_clk) disable iff (!rst_b)
         (accept && !cond_true) |-> done ##1 (!pc_load_r && !busy);
   endproperty
   a_not_taken: assert property (p_not_taken) else $error("false branch not one cycle"); // RULE14

   property p_flag_set;
      @(posedge ref_clk) disable iff (!rst_b)
         (accept && op == OP_FLAG_SET) |=> (pc_load_r == $past(status_flags_word[flag_idx]));
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("flag-set branch wrong"); // RULE1

   property p_flag_clear;
      @(posedge ref_clk) disable iff (!rst_b)
         (accept && op == OP_FLAG_CLEAR) |=> (pc_load_r != $past(status_flags_word[flag_idx]));
   endproperty
   a_flag_clear: assert property (p_flag_clear) else $error("flag-clear branch wrong"); // RULE2

   property p_equal;
      @(posedge ref_clk) disable iff (!rst_b)
         (accept && op == OP_EQUAL) |=> (pc_load_r == $past(status_flags_word[FLAG_Z]));
   endproperty
   a_equal: assert property (p_equal) else $error("equal branch wrong"); // RULE3

   property p_not_equal;
      @(posedge ref_clk) disable iff (!rst_b)
         (accept && op == OP_NOT_EQUAL) |=> (pc_load_r != $past(status_flags_word[FLAG_Z]));
   endproperty
   a_not_equal: assert property (p_not_equal) else $error("not-equal branch wrong"); // RULE4

   property p_carry_set;
      @(posedge ref_clk) disable iff (!rst_b)
         (accept && (op == OP_CARRY_SET || op == OP_UNSIGNED_LOWER)) |->
            (cond_true == status_flags_word[FLAG_C]);
   endproperty
   a_carry_set: assert property (p_carry_set) else $error("carry-set branch wrong"); // RULE5

   property p_carry_clear;
      @(posedge ref_clk) disable iff (!rst_b)
         (accept && (op == OP_CARRY_CLEAR || op == OP_SAME_OR_HIGHER)) |->
            (cond_true != status_flags_word[FLAG_C]);
   endproperty
   a_carry_clear: assert property (p_carry_clear) else $error("carry-clear branch wrong"); // RULE6

   property p_negative;
      @(posedge ref_clk) disable iff (!rst_b)
         (accept && op == OP_NEGATIVE) |-> (cond_true == status_flags_word[FLAG_N]);
   endproperty
   a_negative: assert property (p_negative) else $error("negative branch wrong"); // RULE7

   property p_positive;
      @(posedge ref_clk) disable iff (!rst_b)
         (accept && op == OP_POSITIVE) |-> (cond_true != status_flags_word[FLAG_N]);
   endproperty
   a_positive: assert property (p_positive) else $error("positive branch wrong"); // RULE8

   property p_signed_ge;
      @(posedge ref_clk) disable iff (!rst_b)
         (accept && op == OP_SIGNED_GE) |->
            (cond_true == !(status_flags_word[FLAG_N] ^ status_flags_word[FLAG_V]));
   endproperty
   a_signed_ge: assert property (p_signed_ge) else $error("signed-ge branch wrong"); // RULE9

   property p_signed_less;
      @(posedge ref_clk) disable iff (!rst_b)
         (accept && op == OP_SIGNED_LESS) |->
            (cond_true == (status_flags_word[FLAG_N] ^ status_flags_word[FLAG_V]));
   endproperty
   a_signed_less: assert property (p_signed_less) else $error("signed-less branch wrong"); // RULE10

   property p_half_set;
      @(posedge ref_clk) disable iff (!rst_b)
         (accept && op == OP_HALF_SET) |-> (cond_true == status_flags_word[FLAG_H]);
   endproperty
   a_half_set: assert property (p_half_set) else $error("half-set branch wrong"); // RULE11

   property p_half_clear;
      @(posedge ref_clk) disable iff (!rst_b)
         (accept && op == OP_HALF_CLEAR) |-> (cond_true != status_flags_word[FLAG_H]);
   endproperty
   a_half_clear: assert property (p_half_clear) else $error("half-clear branch wrong"); // RULE12

   property p_copy_bit;
      @(posedge ref_clk) disable iff (!rst_b)
         (accept && op == OP_COPY_BIT_SET) |-> (cond_true == status_flags_word[FLAG_T]);
   endproperty
   a_copy_bit: assert property (p_copy_bit) else $error("copy-bit branch wrong"); // RULE13

   property p_busy_one;
      @(posedge ref_clk) disable iff (!rst_b)
         busy |=> !busy;
   endproperty
   a_busy_one: assert property (p_busy_one) else $error("taken branch exceeds two cycles"); // RULE14

   // Each fixed-flag branch must carry its condition through to the PC load
   property p_carry_set_load;
      @(posedge ref_clk) disable iff (!rst_b)
         (accept && (op == OP_CARRY_SET || op == OP_UNSIGNED_LOWER)) |=>
            (pc_load_r == $past(status_flags_word[FLAG_C]));
   endproperty
   a_carry_set_load: assert property (p_carry_set_load) else $error("carry-set branch load wrong"); // RULE5

   property p_carry_clear_load;
      @(posedge ref_clk) disable iff (!rst_b)
         (accept && (op == OP_CARRY_CLEAR || op == OP_SAME_OR_HIGHER)) |=>
            (pc_load_r != $past(status_flags_word[FLAG_C]));
   endproperty
   a_carry_clear_load: assert property (p_carry_clear_load) else $error("carry-clear branch load wrong"); // RULE6

   property p_negative_load;
      @(posedge ref_clk) disable iff (!rst_b)
         (accept && op == OP_NEGATIVE) |=> (pc_load_r == $past(status_flags_word[FLAG_N]));
   endproperty
   a_negative_load: assert property (p_negative_load) else $error("negative branch load wrong"); // RULE7

   property p_positive_load;
      @(posedge ref_clk) disable iff (!rst_b)
         (accept && op == OP_POSITIVE) |=> (pc_load_r != $past(status_flags_word[FLAG_N]));
   endproperty
   a_positive_load: assert property (p_positive_load) else $error("positive branch load wrong"); // RULE8

   property p_signed_ge_load;
      @(posedge ref_clk) disable iff (!rst_b)
         (accept && op == OP_SIGNED_GE) |=>
            (pc_load_r == $past(status_flags_word[FLAG_N] == status_flags_word[FLAG_V]));
   endproperty
   a_signed_ge_load: assert property (p_signed_ge_load) else $error("signed-ge branch load wrong"); // RULE9

   property p_signed_less_load;
      @(posedge ref_clk) disable iff (!rst_b)
         (accept && op == OP_SIGNED_LESS) |=>
            (pc_load_r == $past(status_flags_word[FLAG_N] ^ status_flags_word[FLAG_V]));
   endproperty
   a_signed_less_load: assert property (p_signed_less_load) else $error("signed-less branch load wrong"); // RULE10

   property p_half_set_load;
      @(posedge ref_clk) disable iff (!rst_b)
         (accept && op == OP_HALF_SET) |=> (pc_load_r == $past(status_flags_word[FLAG_H]));
   endproperty
   a_half_set_load: assert property (p_half_set_load) else $error("half-set branch load wrong"); // RULE11

   property p_half_clear_load;
      @(posedge ref_clk) disable iff (!rst_b)
         (accept && op == OP_HALF_CLEAR) |=> (pc_load_r != $past(status_flags_word[FLAG_H]));
   endproperty
   a_half_clear_load: assert property (p_half_clear_load) else $error("half-clear branch load wrong"); // RULE12

   property p_copy_bit_load;
      @(posedge ref_clk) disable iff (!rst_b)
         (accept && op == OP_COPY_BIT_SET) |=> (pc_load_r == $past(status_flags_word[FLAG_T]));
   endproperty
   a_copy_bit_load: assert property (p_copy_bit_load) else $error("copy-bit branch load wrong"); // RULE13

   // The empty code never branches
   property p_none_load;
      @(posedge ref_clk) disable iff (!rst_b)
         (accept && op == OP_NONE) |=> !pc_load_r;
   endproperty
   a_none_load: assert property (p_none_load) else $error("empty op loaded the PC"); // RULE14

   // Taken branch: silent in the accept cycle, retires in the next, then idle
   sequence s_second;
      busy && done && taken_r;
   endsequence

   property p_take_not_done;
      @(posedge ref_clk) disable iff (!rst_b)
         s_take |-> !done;
   endproperty
   a_take_not_done: assert property (p_take_not_done) else $error("taken branch retired too early"); // RULE14

   property p_taken_span;
      @(posedge ref_clk) disable iff (!rst_b)
         s_take |=> s_second ##1 !busy;
   endproperty
   a_taken_span: assert property (p_taken_span) else $error("taken branch not two cycles"); // RULE14

   property p_busy_done;
      @(posedge ref_clk) disable iff (!rst_b)
         busy |-> done;
   endproperty
   a_busy_done: assert property (p_busy_done) else $error("second cycle did not retire"); // RULE14

   // Load, taken and busy are one pulse in the same cycle
   property p_pulse_pair;
      @(posedge ref_clk) disable iff (!rst_b)
         (pc_load_r == taken_r) && (busy == pc_load_r);
   endproperty
   a_pulse_pair: assert property (p_pulse_pair) else $error("load, taken and busy disagree"); // RULE14

   // A load never repeats on the following edge
   property p_load_one;
      @(posedge ref_clk) disable iff (!rst_b)
         pc_load_r |=> !pc_load_r;
   endproperty
   a_load_one: assert property (p_load_one) else $error("PC load longer than one cycle"); // RULE14

   // Issue seen while busy is refused without any trace
   property p_refuse_busy;
      @(posedge ref_clk) disable iff (!rst_b)
         (busy && issue) |=> (!pc_load_r && !busy);
   endproperty
   a_refuse_busy: assert property (p_refuse_busy) else $error("issue accepted while busy"); // RULE14

   // Target only moves on a taken branch
   property p_target_hold;
      @(posedge ref_clk) disable iff (!rst_b)
         !(accept && cond_true) |=> $stable(pc_target_r);
   endproperty
   a_target_hold: assert property (p_target_hold) else $error("target moved without a taken branch"); // RULE14
endmodule
`default_nettype wire
